// ===== can_xcvr_consts.svh
/*
  Timing constants of the transceiver mode control: each time in its
  own unit, then the derived count of 40 MHz clock cycles.
  Assumes the including file works at the clock period given here.
*/
`ifndef CAN_XCVR_CONSTS_SVH
`define CAN_XCVR_CONSTS_SVH

`define CLK_PERIOD_NS 25

// least times round up to whole cycles
`define T_MODE_NS 20000
`define MODE_CYCLES ((`T_MODE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_FILTER_NS 1000
`define FILTER_CYCLES \
  ((`T_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WAKE_DELAY_NS 2000
`define WAKE_DELAY_CYCLES \
  ((`T_WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_TXD_TIMEOUT_US 2000
`define TXD_TIMEOUT_CYCLES \
  ((`T_TXD_TIMEOUT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_PON_US 280
`define PON_CYCLES ((`T_PON_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// longest time rounds down
`define T_WAKE_WINDOW_US 1000
`define WAKE_WINDOW_CYCLES ((`T_WAKE_WINDOW_US * 1000) / `CLK_PERIOD_NS)

`endif

// ===== can_xcvr_pkg.sv
/*
  Types shared by the transceiver mode control.
  Assumes counters never need more than 17 bits.
*/
package can_xcvr_pkg;

  typedef logic [16:0] cnt_t;

  typedef enum logic [2:0] {
    st_power_down,
    st_standby,
    st_to_normal,
    st_normal,
    st_to_standby
  } op_mode_t;

  typedef enum logic [1:0] {
    wk_idle,
    wk_wait_rec,
    wk_wait_dom
  } wake_t;

endpackage : can_xcvr_pkg

// ===== sync_filter3.sv
/*
  Three-flop synchroniser for one asynchronous pin; the output takes a
  new level only when the second and third flops agree.
  Assumes clk_in is the only clock.
*/
`timescale 1ns/1ps
module sync_filter3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // pin and result
  input wire logic async_in,
  output logic level_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_out <= RESET_VAL;
    end else if (s2_ff == s3_ff) begin
      level_out <= s3_ff;
    end
  end

endmodule : sync_filter3

// ===== can_transceiver_mode_control.sv
/*
  Mode control of a CAN bus transceiver: normal, stand-by and
  power-down, transmit gating, wake pattern detection, transmit
  time-out, supply undervoltage and overtemperature blocking.
  Assumes analog comparators deliver supply, bus and temperature
  states as asynchronous logic levels; pull-ups are outside.
*/
`timescale 1ns/1ps
`include "can_xcvr_consts.svh"

module can_transceiver_mode_control
  import can_xcvr_pkg::*;
#(
  parameter cnt_t WAKE_WINDOW_CYCLES = cnt_t'(`WAKE_WINDOW_CYCLES),
  parameter cnt_t TXD_TIMEOUT_CYCLES = cnt_t'(`TXD_TIMEOUT_CYCLES),
  parameter cnt_t PON_CYCLES = cnt_t'(`PON_CYCLES)
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // protocol controller side
  input wire logic mode_select_in,
  input wire logic txd_in,
  output logic rxd_out,
  // bus receiver and transmitter
  input wire logic bus_dominant_in,
  output logic bus_drive_dominant_out,
  output logic bus_bias_active_out,
  output logic bus_bias_ground_out,
  output logic receiver_enable_out,
  // monitors
  input wire logic logic_supply_ok_in,
  input wire logic tx_supply_uv_rising_in,
  input wire logic tx_supply_uv_falling_in,
  input wire logic overtemp_in,
  // status
  output logic normal_mode_out,
  output logic power_down_out,
  output logic wake_detected_out,
  output logic tx_timeout_out
);

  localparam cnt_t MODE_CYC = cnt_t'(`MODE_CYCLES);
  localparam cnt_t FILT_CYC = cnt_t'(`FILTER_CYCLES);
  localparam cnt_t WU_DLY_CYC = cnt_t'(`WAKE_DELAY_CYCLES);

  logic mode_sel_s;
  logic txd_s;
  logic bus_dom_s;
  logic io_ok_s;
  logic vcc_rise_ok_s;
  logic vcc_fall_ok_s;
  logic overtemp_s;

  // pins idle high so an open board settles in stand-by
  sync_filter3 #(.RESET_VAL(1'b1)) u_sync_mode (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .async_in(mode_select_in), .level_out(mode_sel_s));
  sync_filter3 #(.RESET_VAL(1'b1)) u_sync_txd (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .async_in(txd_in), .level_out(txd_s));
  sync_filter3 #(.RESET_VAL(1'b0)) u_sync_bus (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .async_in(bus_dominant_in), .level_out(bus_dom_s));
  sync_filter3 #(.RESET_VAL(1'b0)) u_sync_io (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .async_in(logic_supply_ok_in), .level_out(io_ok_s));
  sync_filter3 #(.RESET_VAL(1'b0)) u_sync_vr (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .async_in(tx_supply_uv_rising_in), .level_out(vcc_rise_ok_s));
  sync_filter3 #(.RESET_VAL(1'b0)) u_sync_vf (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .async_in(tx_supply_uv_falling_in), .level_out(vcc_fall_ok_s));
  sync_filter3 #(.RESET_VAL(1'b0)) u_sync_ot (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .async_in(overtemp_in), .level_out(overtemp_s));

  op_mode_t mode_ff;
  cnt_t timer_ff;

  // supply loss overrides every other request
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_ff <= st_power_down;
      timer_ff <= '0;
    end else if (!io_ok_s) begin
      mode_ff <= st_power_down;
      timer_ff <= '0;
    end else begin
      unique case (mode_ff)
        st_power_down: begin
          if (timer_ff >= PON_CYCLES - cnt_t'(1)) begin
            mode_ff <= st_standby;
            timer_ff <= '0;
          end else begin
            timer_ff <= timer_ff + cnt_t'(1);
          end
        end
        st_standby: begin
          timer_ff <= '0;
          if (!mode_sel_s && vcc_rise_ok_s) begin
            mode_ff <= st_to_normal;
          end
        end
        st_to_normal: begin
          if (mode_sel_s) begin
            mode_ff <= st_standby;
            timer_ff <= '0;
          end else if (timer_ff >= MODE_CYC - cnt_t'(1)) begin
            mode_ff <= st_normal;
            timer_ff <= '0;
          end else begin
            timer_ff <= timer_ff + cnt_t'(1);
          end
        end
        st_normal: begin
          timer_ff <= '0;
          if (mode_sel_s) begin
            mode_ff <= st_to_standby;
          end
        end
        st_to_standby: begin
          if (timer_ff >= MODE_CYC - cnt_t'(1)) begin
            mode_ff <= st_standby;
            timer_ff <= '0;
          end else begin
            timer_ff <= timer_ff + cnt_t'(1);
          end
        end
      endcase
    end
  end

  // transmit path armed only after a recessive input
  logic path_ok_ff;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      path_ok_ff <= 1'b0;
    end else if (mode_ff == st_to_normal || mode_ff == st_normal) begin
      if (txd_s) begin
        path_ok_ff <= 1'b1;
      end
    end else begin
      path_ok_ff <= 1'b0;
    end
  end

  // dominant time-out, released by a rising edge or by leaving normal mode
  logic timeout_ff;
  logic txd_prev_ff;
  cnt_t txd_low_cnt_ff;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timeout_ff <= 1'b0;
      txd_prev_ff <= 1'b1;
      txd_low_cnt_ff <= '0;
    end else begin
      txd_prev_ff <= txd_s;
      if (mode_ff != st_normal) begin
        timeout_ff <= 1'b0;
        txd_low_cnt_ff <= '0;
      end else if (txd_s) begin
        txd_low_cnt_ff <= '0;
        if (!txd_prev_ff) begin
          timeout_ff <= 1'b0;
        end
      end else if (txd_low_cnt_ff >= TXD_TIMEOUT_CYCLES) begin
        timeout_ff <= 1'b1;
      end else begin
        txd_low_cnt_ff <= txd_low_cnt_ff + cnt_t'(1);
      end
    end
  end

  // bus level passed only when steady longer than the filter time
  logic filt_dom_ff;
  cnt_t filt_cnt_ff;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filt_dom_ff <= 1'b0;
      filt_cnt_ff <= '0;
    end else if (bus_dom_s == filt_dom_ff) begin
      filt_cnt_ff <= '0;
    end else if (filt_cnt_ff >= FILT_CYC) begin
      filt_dom_ff <= bus_dom_s;
      filt_cnt_ff <= '0;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + cnt_t'(1);
    end
  end

  // wake pattern on the filtered level, window from first dominant
  wake_t wake_ff;
  cnt_t win_cnt_ff;
  logic woken_ff;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_ff <= wk_idle;
      win_cnt_ff <= '0;
      woken_ff <= 1'b0;
    end else if (mode_ff != st_standby) begin
      wake_ff <= wk_idle;
      win_cnt_ff <= '0;
      woken_ff <= 1'b0;
    end else begin
      unique case (wake_ff)
        wk_idle: begin
          win_cnt_ff <= '0;
          if (filt_dom_ff && !woken_ff) begin
            wake_ff <= wk_wait_rec;
          end
        end
        wk_wait_rec, wk_wait_dom: begin
          if (win_cnt_ff >= WAKE_WINDOW_CYCLES) begin
            wake_ff <= wk_idle;
          end else begin
            win_cnt_ff <= win_cnt_ff + cnt_t'(1);
            if (wake_ff == wk_wait_rec && !filt_dom_ff) begin
              wake_ff <= wk_wait_dom;
            end else if (wake_ff == wk_wait_dom && filt_dom_ff) begin
              wake_ff <= wk_idle;
              woken_ff <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // delayed copy of the filtered bus after wake; a delay line, since a
  // settle counter would swallow phases shorter than the delay
  logic [WU_DLY_CYC-1:0] dly_line_ff;
  logic follow_dom;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dly_line_ff <= '0;
    end else begin
      dly_line_ff <= {dly_line_ff[WU_DLY_CYC-2:0], filt_dom_ff};
    end
  end
  assign follow_dom = dly_line_ff[WU_DLY_CYC-1];

  logic in_normal;
  logic nxt_drive;
  logic nxt_rxd;
  always_comb begin
    in_normal = (mode_ff == st_normal) || (mode_ff == st_to_standby);
    nxt_drive = in_normal && path_ok_ff && !timeout_ff &&
      !overtemp_s && vcc_fall_ok_s && !txd_s;
    unique case (mode_ff)
      st_normal, st_to_standby: nxt_rxd = !bus_dom_s;
      st_standby: nxt_rxd = !(woken_ff && follow_dom);
      default: nxt_rxd = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rxd_out <= 1'b1;
      bus_drive_dominant_out <= 1'b0;
      bus_bias_active_out <= 1'b0;
      bus_bias_ground_out <= 1'b0;
      receiver_enable_out <= 1'b0;
      normal_mode_out <= 1'b0;
      power_down_out <= 1'b1;
      wake_detected_out <= 1'b0;
      tx_timeout_out <= 1'b0;
    end else begin
      rxd_out <= nxt_rxd;
      bus_drive_dominant_out <= nxt_drive;
      bus_bias_active_out <= in_normal && vcc_fall_ok_s;
      bus_bias_ground_out <= in_normal && !vcc_fall_ok_s;
      receiver_enable_out <= mode_ff != st_power_down;
      normal_mode_out <= mode_ff == st_normal;
      power_down_out <= mode_ff == st_power_down;
      wake_detected_out <= woken_ff;
      tx_timeout_out <= timeout_ff;
    end
  end

endmodule : can_transceiver_mode_control

// ===== can_bus_model.sv
/*
  Bus model for the transceiver bench: wired-or of this node and others.
  Assumes the bench drives all other nodes as one dominant flag.
*/
`timescale 1ns/1ps
module can_bus_model (
  // transmitters on the bus
  input wire logic drive_dominant_in,
  input wire logic other_dominant_in,
  // comparator result
  output logic bus_dominant_out
);
  // dominant from any node wins
  assign bus_dominant_out = drive_dominant_in | other_dominant_in;
endmodule : can_bus_model

// ===== can_transceiver_mode_control_chk.sv
/*
  Checker for the transceiver mode control, bound to its ports.
  Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module can_xcvr_mode_chk
  import can_xcvr_pkg::*;
#(
  parameter cnt_t TXD_TIMEOUT_CYCLES = 17'h64,
  parameter cnt_t PON_CYCLES = 17'h14
) (
  // watched inputs
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic txd_in,
  input wire logic bus_dominant_in,
  input wire logic logic_supply_ok_in,
  input wire logic tx_supply_uv_falling_in,
  input wire logic overtemp_in,
  // watched outputs
  input wire logic rxd_out,
  input wire logic bus_drive_dominant_out,
  input wire logic bus_bias_active_out,
  input wire logic bus_bias_ground_out,
  input wire logic receiver_enable_out,
  input wire logic normal_mode_out,
  input wire logic power_down_out,
  input wire logic wake_detected_out,
  input wire logic tx_timeout_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  cnt_t ok_cnt_ff;
  cnt_t low_cnt_ff;
  // pin-side counts; the design's synchroniser only makes its own shorter
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) ok_cnt_ff <= '0;
    else if (!logic_supply_ok_in) ok_cnt_ff <= '0;
    else if (ok_cnt_ff != '1) ok_cnt_ff <= ok_cnt_ff + 1'b1;
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) low_cnt_ff <= '0;
    else if (txd_in) low_cnt_ff <= '0;
    else if (low_cnt_ff != '1) low_cnt_ff <= low_cnt_ff + 1'b1;
  end
  sequence s_enter;
    !normal_mode_out ##1 normal_mode_out;
  endsequence
  sequence s_hot;
    overtemp_in [*8];
  endsequence
  property p_pd_quiet;
    power_down_out |-> rxd_out && !bus_drive_dominant_out &&
      !bus_bias_active_out && !receiver_enable_out;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("outputs active in power-down");
  property p_pon;
    $fell(power_down_out) |-> ok_cnt_ff >= PON_CYCLES;
  endproperty
  a_pon: assert property (p_pon)
    else $error("power-down left too early");
  property p_wake;
    wake_detected_out |-> !normal_mode_out && !bus_drive_dominant_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake changed mode or drove bus");
  property p_enter_rx;
    s_enter |-> $past(rxd_out, 2);
  endproperty
  a_enter_rx: assert property (p_enter_rx)
    else $error("receive output not high during mode change");
  property p_tout;
    $rose(tx_timeout_out) |-> low_cnt_ff > TXD_TIMEOUT_CYCLES;
  endproperty
  a_tout: assert property (p_tout)
    else $error("time-out before input low long enough");
  property p_hot;
    s_hot |-> !bus_drive_dominant_out;
  endproperty
  a_hot: assert property (p_hot)
    else $error("driving while overheated");
  property p_txuv;
    (normal_mode_out && !tx_supply_uv_falling_in) [*8] |->
      bus_bias_ground_out && !bus_drive_dominant_out;
  endproperty
  a_txuv: assert property (p_txuv)
    else $error("transmitter supply low not blocking");
  property p_normal_rx;
    (normal_mode_out && bus_dominant_in) [*8] |-> !rxd_out;
  endproperty
  a_normal_rx: assert property (p_normal_rx)
    else $error("dominant bus not shown on receive output");
endmodule : can_xcvr_mode_chk

bind can_transceiver_mode_control can_xcvr_mode_chk #(
  .TXD_TIMEOUT_CYCLES(TXD_TIMEOUT_CYCLES), .PON_CYCLES(PON_CYCLES)
) chk_u (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .txd_in(txd_in),
  .bus_dominant_in(bus_dominant_in),
  .logic_supply_ok_in(logic_supply_ok_in),
  .tx_supply_uv_falling_in(tx_supply_uv_falling_in),
  .overtemp_in(overtemp_in), .rxd_out(rxd_out),
  .bus_drive_dominant_out(bus_drive_dominant_out),
  .bus_bias_active_out(bus_bias_active_out),
  .bus_bias_ground_out(bus_bias_ground_out),
  .receiver_enable_out(receiver_enable_out),
  .normal_mode_out(normal_mode_out), .power_down_out(power_down_out),
  .wake_detected_out(wake_detected_out), .tx_timeout_out(tx_timeout_out)
);

// ===== can_transceiver_mode_control_bench.sv
/*
  Self-checking bench for the transceiver mode control.
  Assumes short simulation counts: window 200, time-out 100, power-on 20.
*/
`timescale 1ns/1ps
module can_transceiver_mode_control_bench;
  typedef struct {int id; logic val;} note_t;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic mode_sel = 1'b1;
  logic txd = 1'b1;
  logic other_dom = 1'b0;
  logic sup_ok = 1'b1;
  logic uv_r = 1'b1;
  logic uv_f = 1'b1;
  logic hot = 1'b0;
  logic bus_dom;
  wire [8:0] outs;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h168e0;
  note_t q[$];
  event check_ev;
  string nm[9] = '{"rxd", "drive", "bias", "bias_gnd", "rx_en", "normal",
                   "power_down", "wake", "timeout"};

  can_transceiver_mode_control #(
    .WAKE_WINDOW_CYCLES(17'hc8), .TXD_TIMEOUT_CYCLES(17'h64),
    .PON_CYCLES(17'h14)
  ) dut_u (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .mode_select_in(mode_sel),
    .txd_in(txd), .rxd_out(outs[0]), .bus_dominant_in(bus_dom),
    .bus_drive_dominant_out(outs[1]), .bus_bias_active_out(outs[2]),
    .bus_bias_ground_out(outs[3]), .receiver_enable_out(outs[4]),
    .logic_supply_ok_in(sup_ok), .tx_supply_uv_rising_in(uv_r),
    .tx_supply_uv_falling_in(uv_f), .overtemp_in(hot),
    .normal_mode_out(outs[5]), .power_down_out(outs[6]),
    .wake_detected_out(outs[7]), .tx_timeout_out(outs[8])
  );
  can_bus_model bus_u (
    .drive_dominant_in(outs[1]), .other_dominant_in(other_dom),
    .bus_dominant_out(bus_dom)
  );

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic cyc(int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  // sampled mid-cycle so the edge's updates have landed
  task automatic note(int id, logic v);
    q.push_back('{id, v});
    -> check_ev;
    @(posedge clk_in);
  endtask : note
  task automatic chk(int id, logic v);
    @(negedge clk_in);
    note(id, v);
  endtask : chk
  task automatic wait_chk(int id, logic v, int n);
    @(negedge clk_in);
    for (int i = 0; i < n && outs[id] !== v; i++) @(negedge clk_in);
    note(id, v);
  endtask : wait_chk
  task automatic bus(logic v, int n);
    other_dom <= v;
    cyc(n);
  endtask : bus
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  always @(check_ev) begin : monitor
    note_t e;
    while (q.size() > 0) begin
      e = q.pop_front();
      total_checks++;
      if (outs[e.id] !== e.val) begin
        miscompares++;
        $display("mismatch %s expected %b seen %b", nm[e.id], e.val,
                 outs[e.id]);
      end
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin : main
    logic b;
    cyc(10);
    chk(6, 1'b1);
    cyc(9);
    reset_n_in <= 1'b1;
    wait_chk(6, 1'b0, 60);
    chk(5, 1'b0);
    // dominant pulses under the filter time never wake
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      bus(1'b1, 1 + seed % 30);
      chk(0, 1'b1);
      bus(1'b0, 50);
    end
    bus(1'b1, 60);
    bus(1'b0, 250);
    bus(1'b1, 60);
    chk(7, 1'b0);
    bus(1'b0, 60);
    bus(1'b1, 60);
    wait_chk(7, 1'b1, 30);
    chk(5, 1'b0);
    cyc(150);
    chk(0, 1'b0);
    bus(1'b0, 2);
    chk(0, 1'b0);
    cyc(150);
    chk(0, 1'b1);
    // a phase longer than the filter but shorter than the delay
    bus(1'b1, 60);
    bus(1'b0, 70);
    chk(0, 1'b0);
    uv_r <= 1'b0;
    mode_sel <= 1'b0;
    txd <= 1'b0;
    cyc(900);
    chk(5, 1'b0);
    uv_r <= 1'b1;
    other_dom <= 1'b1;
    cyc(20);
    chk(0, 1'b1);
    wait_chk(5, 1'b1, 900);
    chk(0, 1'b0);
    chk(1, 1'b0);
    other_dom <= 1'b0;
    txd <= 1'b1;
    cyc(10);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      b = seed[0];
      txd <= b;
      cyc(20);
      chk(1, !b);
      chk(0, b);
      txd <= 1'b1;
      cyc(6);
    end
    txd <= 1'b0;
    cyc(140);
    chk(8, 1'b1);
    chk(1, 1'b0);
    other_dom <= 1'b1;
    cyc(10);
    chk(0, 1'b0);
    other_dom <= 1'b0;
    txd <= 1'b1;
    cyc(10);
    chk(8, 1'b0);
    txd <= 1'b0;
    hot <= 1'b1;
    cyc(10);
    chk(1, 1'b0);
    chk(5, 1'b1);
    hot <= 1'b0;
    cyc(10);
    chk(1, 1'b1);
    uv_f <= 1'b0;
    cyc(10);
    chk(3, 1'b1);
    chk(1, 1'b0);
    txd <= 1'b1;
    uv_f <= 1'b1;
    cyc(10);
    chk(2, 1'b1);
    mode_sel <= 1'b1;
    wait_chk(5, 1'b0, 20);
    cyc(820);
    txd <= 1'b0;
    cyc(10);
    chk(1, 1'b0);
    // request withdrawn mid-change must fall back to stand-by
    mode_sel <= 1'b0;
    other_dom <= 1'b1;
    cyc(100);
    mode_sel <= 1'b1;
    cyc(850);
    chk(0, 1'b1);
    other_dom <= 1'b0;
    txd <= 1'b1;
    sup_ok <= 1'b0;
    cyc(10);
    chk(6, 1'b1);
    chk(4, 1'b0);
    sup_ok <= 1'b1;
    wait_chk(6, 1'b0, 60);
    chk(5, 1'b0);
    conclude();
  end
endmodule : can_transceiver_mode_control_bench
